/* rtl/asf_pkg.sv */
package asf_pkg;
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] SWTRIG_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] DATA_OFF = 8'h0c;
  localparam logic [7:0] STOPCNT_OFF = 8'h10;
  localparam logic [7:0] DIVISOR_OFF = 8'h14;
  // Control field positions
  localparam int CTRL_PRETRIGGER_INPUT_BIT = 0;
  localparam int CTRL_EOC_IRQ_BIT = 1;
  localparam int CTRL_HALF_IRQ_BIT = 2;
  localparam int CTRL_RES16_BIT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Status field positions
  localparam int ST_NOT_EMPTY_BIT = 0;
  localparam int ST_HALF_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_IDLE_BIT = 3;
  localparam int ST_GATE_BIT = 4;
  localparam int ST_STOPPED_BIT = 5;
  // Sample store
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 1024;
  localparam int PTR_W = 10;
  localparam int COUNT_W = 11;
  localparam logic [10:0] FIFO_FULL_LEVEL = 11'h400;
  localparam logic [10:0] FIFO_HALF_LEVEL = 11'h200;
  // Stop counter
  localparam int STOP_W = 16;
  localparam logic [15:0] STOP_RST = 16'h0001;
  // Full-scale divisors per resolution
  localparam logic [31:0] DIV_16BIT = 32'h0000_8000;
  localparam logic [31:0] DIV_12BIT = 32'h0000_0800;
  // Conversion deadline, longest time rounds down
  localparam int CLK_PERIOD_PS = 20000;
  localparam int CONV_TIME_PS = 8500000;
  localparam int CONV_CYCLES = CONV_TIME_PS / CLK_PERIOD_PS;
  localparam int CONV_CNT_W = 9;
  // Converter sequencer states, gray from idle to run to done
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_DONE = 2'b11
  } conv_state_type;

  // Word layout for both resolutions
  function automatic logic [15:0] format_sample(input logic res16,
      input logic [15:0] raw, input logic [3:0] chan);
    format_sample = res16 ? raw : {raw[11:0], chan};
  endfunction
endpackage

/* rtl/asf_ifs.sv */
`timescale 1ns/100ps
// Store side of the sample buffer
interface asf_fifo_if;
  logic push;
  logic [15:0] push_data;
  logic pop;
  logic [15:0] head;
  logic [10:0] count;
  logic full;
  logic empty;
  modport user(output push, push_data, pop, input head, count, full, empty);
  modport store(input push, push_data, pop, output head, count, full, empty);
endinterface // asf_fifo_if

// Conversion sequencer hookup
interface asf_conv_if;
  logic go;
  logic idle;
  logic done;
  logic [15:0] raw;
  logic [3:0] chan;
  modport user(output go, input idle, done, raw, chan);
  modport unit(input go, output idle, done, raw, chan);
endinterface // asf_conv_if

/* rtl/asf_fifo.sv */
`timescale 1ns/100ps
module asf_fifo (
  input wire logic clk_i,
  input wire logic rst_n_i,
  asf_fifo_if.store fif
);
  logic [15:0] mem [0:asf_pkg::FIFO_DEPTH-1]; // Sample words
  logic [9:0] wr_ptr_ff; // Next slot to fill
  logic [9:0] rd_ptr_ff; // Oldest word
  logic [10:0] count_ff; // Words held
  wire do_push;
  wire do_pop;

  // Push into a full store is dropped, contents kept
  assign do_push = fif.push & ~fif.full;
  assign do_pop = fif.pop & ~fif.empty;
  assign fif.full = (count_ff == asf_pkg::FIFO_FULL_LEVEL);
  assign fif.empty = (count_ff == 11'h000);
  assign fif.count = count_ff;
  assign fif.head = mem[rd_ptr_ff];

  // Array has no reset; pointers define validity
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= fif.push_data;
    end
  end

  // Pointers and fill level, empty at reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= 10'h000;
      rd_ptr_ff <= 10'h000;
      count_ff <= 11'h000;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + {9'h000, do_push};
      rd_ptr_ff <= rd_ptr_ff + {9'h000, do_pop};
      count_ff <= count_ff + {10'h000, do_push} - {10'h000, do_pop};
    end
  end
endmodule // asf_fifo

/* rtl/asf_conv.sv */
`timescale 1ns/100ps
module asf_conv (
  input wire logic clk_i,
  input wire logic rst_n_i,
  asf_conv_if.unit cif,
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [15:0] adc_data_i,
  input wire logic [3:0] adc_channel_i
);
  asf_pkg::conv_state_type state_ff; // Sequencer state
  asf_pkg::conv_state_type nxt_state;
  logic [8:0] tick_ff; // Cycles since start
  logic [15:0] raw_ff; // Captured code
  logic [3:0] chan_ff; // Captured channel
  logic start_ff; // Start pulse to converter
  wire deadline;
  wire finish;

  // Hard deadline: a late converter is cut off
  assign deadline = (tick_ff == 9'(asf_pkg::CONV_CYCLES - 1));
  assign finish = (state_ff == asf_pkg::CONV_RUN) & (adc_done_i | deadline);

  // Next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      asf_pkg::CONV_IDLE: if (cif.go) nxt_state = asf_pkg::CONV_RUN;
      asf_pkg::CONV_RUN: if (finish) nxt_state = asf_pkg::CONV_DONE;
      asf_pkg::CONV_DONE: nxt_state = asf_pkg::CONV_IDLE;
      default: nxt_state = asf_pkg::CONV_IDLE;
    endcase
  end

  // Idle low only while converting
  assign cif.idle = (state_ff != asf_pkg::CONV_RUN);
  assign cif.done = (state_ff == asf_pkg::CONV_DONE);
  assign cif.raw = raw_ff;
  assign cif.chan = chan_ff;
  assign adc_start_o = start_ff;

  // State, timer and capture
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= asf_pkg::CONV_IDLE;
      tick_ff <= 9'h000;
      raw_ff <= 16'h0000;
      chan_ff <= 4'h0;
      start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      start_ff <= (state_ff == asf_pkg::CONV_IDLE) & cif.go;
      tick_ff <= (state_ff == asf_pkg::CONV_RUN) ? tick_ff + 9'h001 : 9'h000;
      if (finish) begin
        raw_ff <= adc_data_i;
        chan_ff <= adc_channel_i;
      end
    end
  end
endmodule // asf_conv

/* rtl/asf_top.sv */
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - Buffer results in 1024-word FIFO
// - Drop new results while store full
// - Store result at once, set not-empty
// - Idle flag low during conversion
// - Conversion finishes within 8.5 us
// - Half-full status at 512 words
// - Full status reported, means overrun
// - EOC interrupt per stored result
// - Half-full interrupt reaching 512 words
// - Pre-trigger mode samples until input
// - Stop counter counts triggers after event
// - Block triggers once counter hits zero
// - N is 1..65535, N samples after
// - 16-bit result passes as two's complement
// - 12-bit result high, channel low
// - Divisor 32768 or 2048 per resolution
// - Gate on falling edge, clear at zero
module asf_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ext_trig_i,
  input wire logic pretrigger_input_i,
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [15:0] adc_data_i,
  input wire logic [3:0] adc_channel_i,
  output logic fifo_not_empty_flag_o,
  output logic conversion_idle_flag_o,
  output logic fifo_half_o,
  output logic fifo_full_o,
  output logic eoc_irq_o,
  output logic half_irq_o,
  output logic acq_stopped_o
);
  // Module carriers
  asf_fifo_if fif ();
  asf_conv_if cif ();


  // Everything below runs on clk_i alone; the pins are taken as already
  // synchronous, so no resampling stage sits in front of them.
  // Register state
  logic [3:0] ctrl_ff; // Mode and select bits
  logic [15:0] stop_load_ff; // Programmed N
  logic [15:0] stop_cnt_ff; // Live stop count
  logic gate_ff; // Counting after the event
  logic stopped_ff; // Acquisition ended
  logic pretrigger_input_prev_ff; // Last pre-trigger level
  logic half_prev_ff; // Last half status
  logic eoc_irq_ff; // End of conversion pulse
  logic half_irq_ff; // Half-full pulse
  logic [31:0] rdata_ff; // Read answer


  // Strobes are exact address matches; a write to any other offset,
  // the read-only ones included, falls through and changes nothing.
  // Decoded register strobes
  wire wr_ctrl;
  wire wr_swtrig;
  wire wr_stop;
  wire rd_data;
  wire [31:0] rd_mux;
  wire [31:0] status_word;
  wire [31:0] divisor;

  // Control fields
  wire pretrigger_input_mode;
  wire eoc_sel;
  wire half_sel;
  wire res16;

  // Trigger, gate and stop logic share one cycle of decision; nothing
  // in this path is pipelined, so a taken trigger is counted at once.
  // Trigger path
  wire trig_req;
  wire trig_allowed;
  wire trig_take;
  wire pretrigger_input_fall;
  wire count_step;
  wire last_count;
  wire half_now;
  wire [15:0] n_value;

  // Register decode
  assign wr_ctrl = wr_i & (addr_i == asf_pkg::CTRL_OFF);
  assign wr_swtrig = wr_i & (addr_i == asf_pkg::SWTRIG_OFF);
  assign wr_stop = wr_i & (addr_i == asf_pkg::STOPCNT_OFF);
  assign rd_data = rd_i & (addr_i == asf_pkg::DATA_OFF);

  // Control field taps
  assign pretrigger_input_mode = ctrl_ff[asf_pkg::CTRL_PRETRIGGER_INPUT_BIT];
  assign eoc_sel = ctrl_ff[asf_pkg::CTRL_EOC_IRQ_BIT];
  assign half_sel = ctrl_ff[asf_pkg::CTRL_HALF_IRQ_BIT];
  assign res16 = ctrl_ff[asf_pkg::CTRL_RES16_BIT];

  // Zero would wrap the counter and stretch the run by a whole span,
  // so the smallest legal count is forced instead.
  // N of zero is out of range; treated as one
  assign n_value = (wdata_i[15:0] == 16'h0000) ? 16'h0001 : wdata_i[15:0];

  // A level held on the external pin asks again every cycle; only the
  // requests that meet an idle sequencer are taken, the rest are lost.
  // Any trigger source, software or external
  assign trig_req = wr_swtrig | ext_trig_i;

  // Once stopped in pre-trigger mode, triggers are blocked
  assign trig_allowed = ~(pretrigger_input_mode & stopped_ff);
  // Outside that, sampling keeps running freely
  assign trig_take = trig_req & trig_allowed & cif.idle;
  assign cif.go = trig_take;

  // The history flop resets high, the idle level of the pin, so a pin
  // parked high at reset release does not look like a fresh event.
  // Falling edge of the pre-trigger pin arms the gate
  assign pretrigger_input_fall = pretrigger_input_prev_ff & ~pretrigger_input_i;

  // Each accepted trigger under the gate counts down
  assign count_step = pretrigger_input_mode & gate_ff & trig_take;
  // Trigger taking the count to zero is still converted
  assign last_count = count_step & (stop_cnt_ff == 16'h0001);

  // The push goes out in the single DONE cycle; when the store is full
  // it is refused inside the store and the word is simply lost.
  // Sample into the store right as conversion ends
  assign fif.push = cif.done;
  assign fif.push_data = asf_pkg::format_sample(res16, cif.raw, cif.chan);
  assign fif.pop = rd_data;

  // Half status from 512 words upward
  assign half_now = (fif.count >= asf_pkg::FIFO_HALF_LEVEL);

  // Divisor matching the selected resolution
  assign divisor = res16 ? asf_pkg::DIV_16BIT : asf_pkg::DIV_12BIT;

  // Status is combinational from the live state, so a read taken in
  // the same cycle as a push shows the level before that push.
  // Status word gathers live flags
  assign status_word = {
    26'h0000000,
    stopped_ff,
    gate_ff,
    cif.idle,
    fif.full,
    half_now,
    ~fif.empty
  };

  // A data read with nothing stored returns zero and pops nothing;
  // software that skips the empty check cannot tell that from a sample.
  // Read multiplexer; unmapped reads give zero
  assign rd_mux =
    (addr_i == asf_pkg::CTRL_OFF) ? {28'h0000000, ctrl_ff} :
    (addr_i == asf_pkg::STATUS_OFF) ? status_word :
    (addr_i == asf_pkg::DATA_OFF) ? (fif.empty ? 32'h0000_0000 : {16'h0000, fif.head}) :
    (addr_i == asf_pkg::STOPCNT_OFF) ? {16'h0000, stop_cnt_ff} :
    (addr_i == asf_pkg::DIVISOR_OFF) ? divisor :
    32'h0000_0000;

  // These outputs repeat the status bits for a host that watches pins
  // instead of polling the status word.
  // Pin level flags straight from state
  assign fifo_not_empty_flag_o = ~fif.empty;
  assign conversion_idle_flag_o = cif.idle;
  assign fifo_half_o = half_now;
  assign fifo_full_o = fif.full;
  assign eoc_irq_o = eoc_irq_ff;
  assign half_irq_o = half_irq_ff;
  assign acq_stopped_o = stopped_ff;
  assign rdata_o = rdata_ff;

  // Depth and pointers live inside the store; only count, head and
  // the two flags come back out.
  // Sample store
  asf_fifo u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .fif(fif.store)
  );

  // The sequencer cuts a silent converter off at the deadline, so the
  // pipeline never hangs waiting for a done pulse.
  // Conversion sequencer
  asf_conv u_conv (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cif(cif.unit),
    .adc_start_o(adc_start_o),
    .adc_done_i(adc_done_i),
    .adc_data_i(adc_data_i),
    .adc_channel_i(adc_channel_i)
  );

  // Writing the control word while a conversion runs is allowed; the
  // new format applies to the word pushed at the end of that run.
  // Control register; mode off after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= asf_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= wdata_i[asf_pkg::CTRL_W-1:0];
    end
  end

  // Stored N, kept for re-arming
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_load_ff <= asf_pkg::STOP_RST;
    end else if (wr_stop) begin
      stop_load_ff <= n_value;
    end
  end

  // Write wins over the reload, so N can be changed with the mode off
  // and is then kept; with the mode on, only writes and gated triggers move it.
  // Live stop counter; reload on write or while mode off
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_cnt_ff <= asf_pkg::STOP_RST;
    end else if (wr_stop) begin
      stop_cnt_ff <= n_value;
    end else if (!pretrigger_input_mode) begin
      stop_cnt_ff <= stop_load_ff;
    end else if (count_step) begin
      stop_cnt_ff <= stop_cnt_ff - 16'h0001;
    end
  end

  // The last count and a new edge in one cycle: the count wins, so the
  // run still ends after exactly N samples.
  // Gate: armed by edge, dropped at zero or mode off
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_ff <= 1'b0;
    end else if (!pretrigger_input_mode) begin
      gate_ff <= 1'b0;
    end else if (last_count) begin
      gate_ff <= 1'b0;
    end else if (pretrigger_input_fall & ~stopped_ff) begin
      gate_ff <= 1'b1;
    end
  end

  // Only mode off releases the stop; a second edge on the pin while
  // stopped is ignored until the host re-arms.
  // Stopped holds until host turns mode off
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stopped_ff <= 1'b0;
    end else if (!pretrigger_input_mode) begin
      stopped_ff <= 1'b0;
    end else if (last_count) begin
      stopped_ff <= 1'b1;
    end
  end

  // Half history starts low, matching the empty store at reset, so no
  // false crossing is seen on the first cycle.
  // Edge history for pin and half status
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pretrigger_input_prev_ff <= 1'b1;
      half_prev_ff <= 1'b0;
    end else begin
      pretrigger_input_prev_ff <= pretrigger_input_i;
      half_prev_ff <= half_now;
    end
  end

  // Both pulses last one cycle and are not latched; a host that needs
  // a held request must catch them in its own interrupt logic.
  // Interrupt pulses; EOC only when the word was kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eoc_irq_ff <= 1'b0;
      half_irq_ff <= 1'b0;
    end else begin
      eoc_irq_ff <= eoc_sel & fif.push & ~fif.full;
      half_irq_ff <= half_sel & half_now & ~half_prev_ff;
    end
  end

  // Clearing between reads keeps the bus quiet; the trade is that the
  // master must take the data in exactly that one cycle.
  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // Block reads of 512 words rest on host checking half
  // and full first; the store does not guard it.
endmodule // asf_top

/* bench/asf_adc_model.sv */
`timescale 1ns/100ps
// Converter stand-in: answers each start after delay_i cycles
module asf_adc_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [9:0] delay_i,
  output logic done_o,
  output logic [15:0] data_o,
  output logic [3:0] chan_o
);
  int wait_q = -1; // Cycles left, -1 when no conversion
  logic [15:0] n_q = 16'h0000; // Next code handed out

  // Known start values so the toggling below is never unknown
  initial begin
    done_o = 1'b0;
    data_o = 16'h5a5a;
    chan_o = 4'ha;
  end

  // Delay 0 means mute, which forces the deadline path
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o; // Lines not valid outside done
    chan_o <= ~chan_o;
    if (start_i && delay_i != 10'h000) begin
      wait_q <= int'(delay_i) - 1;
    end else if (wait_q == 0) begin
      done_o <= 1'b1;
      data_o <= n_q;
      chan_o <= n_q[3:0];
      n_q <= n_q + 16'h0001;
      wait_q <= -1;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule // asf_adc_model

/* bench/asf_top_props.sv */
`timescale 1ns/100ps
// Port-level checks on the sample buffer
module asf_top_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic adc_start_o,
  input wire logic fifo_not_empty_flag_o,
  input wire logic conversion_idle_flag_o,
  input wire logic fifo_half_o,
  input wire logic fifo_full_o,
  input wire logic eoc_irq_o,
  input wire logic half_irq_o,
  input wire logic acq_stopped_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_idle_drop_start: assert property ($fell(conversion_idle_flag_o) |-> adc_start_o)
    else $error("idle fell without a start");
  a_start_busy: assert property (adc_start_o |-> !conversion_idle_flag_o)
    else $error("idle high at start");
  // Idle must come back by the conversion deadline
  a_conv_deadline: assert property (adc_start_o |-> ##[1:426] conversion_idle_flag_o)
    else $error("conversion overran deadline");
  // Pulse only after a run then done cycle, with data present
  a_eoc_after_conv: assert property (eoc_irq_o |->
      fifo_not_empty_flag_o && $past(conversion_idle_flag_o) && !$past(conversion_idle_flag_o, 2))
    else $error("eoc pulse without stored result");
  a_full_is_half: assert property (fifo_full_o |-> fifo_half_o && fifo_not_empty_flag_o)
    else $error("full without half");
  a_half_irq_edge: assert property (half_irq_o |-> $past(fifo_half_o) && !$past(fifo_half_o, 2))
    else $error("half irq off threshold");
  a_full_drop: assert property (fifo_full_o && $past(fifo_full_o) |-> !eoc_irq_o)
    else $error("sample accepted while full");
  a_stop_blocks: assert property (acq_stopped_o && $past(acq_stopped_o) |-> !adc_start_o)
    else $error("start while stopped");
endmodule // asf_top_props

bind asf_top asf_top_props i_props (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .adc_start_o(adc_start_o),
  .fifo_not_empty_flag_o(fifo_not_empty_flag_o),
  .conversion_idle_flag_o(conversion_idle_flag_o),
  .fifo_half_o(fifo_half_o),
  .fifo_full_o(fifo_full_o),
  .eoc_irq_o(eoc_irq_o),
  .half_irq_o(half_irq_o),
  .acq_stopped_o(acq_stopped_o)
);

/* bench/tb_adc_sample_fifo_pretrigger.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, a, e); end end
// Host-side bench for the sample buffer
module tb_adc_sample_fifo_pretrigger;
  logic clk_i, rst_n_i, wr_i, rd_i, ext_trig, pretrigger_input, start, done;
  logic nef, idle, half, full, eoc, hirq, stopped;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [15:0] adata;
  logic [3:0] achan;
  logic [9:0] delay = 10'h003; // Converter answer delay, 0 mutes it
  int fail_count = 0, n_checks = 0, eoc_cnt = 0, half_cnt = 0, start_cnt = 0;
  int nx = 0, base, s0;

  asf_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_trig_i(ext_trig),
    .pretrigger_input_i(pretrigger_input), .adc_start_o(start), .adc_done_i(done), .adc_data_i(adata),
    .adc_channel_i(achan), .fifo_not_empty_flag_o(nef), .conversion_idle_flag_o(idle),
    .fifo_half_o(half), .fifo_full_o(full), .eoc_irq_o(eoc), .half_irq_o(hirq),
    .acq_stopped_o(stopped));
  asf_adc_model i_adc (.clk_i(clk_i), .start_i(start), .delay_i(delay), .done_o(done),
    .data_o(adata), .chan_o(achan));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Pulse counters, sampled on the design's edge
  always @(posedge clk_i) begin
    eoc_cnt <= eoc_cnt + int'(eoc === 1'b1);
    half_cnt <= half_cnt + int'(hirq === 1'b1);
    start_cnt <= start_cnt + int'(start === 1'b1);
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK(rdata_o, e)
  endtask

  // One external trigger, then wait for the push to land
  task automatic conv();
    @(posedge clk_i);
    ext_trig <= 1'b1;
    @(posedge clk_i);
    ext_trig <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 500 && idle !== 1'b1; i++) @(negedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask

  task automatic test_done();
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    test_done();
  end

  initial begin
    {rst_n_i, wr_i, rd_i, ext_trig, addr_i, wdata_i} = '0;
    pretrigger_input = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    `CHK({nef, idle, half, full, stopped}, 5'b01000)
    rdc(asf_pkg::STATUS_OFF, 32'h0000_0008);
    rdc(asf_pkg::DATA_OFF, 32'h0); // Empty pop gives zero
    rdc(8'hfc, 32'h0); // Unmapped address
    // 16-bit format, read after the deadline without polling
    wr(asf_pkg::CTRL_OFF, 32'h0000_000a);
    rdc(asf_pkg::DIVISOR_OFF, asf_pkg::DIV_16BIT);
    wr(asf_pkg::SWTRIG_OFF, 32'h0);
    repeat (426) @(posedge clk_i);
    rdc(asf_pkg::DATA_OFF, 32'(nx));
    `CHK(eoc_cnt, 1)
    nx++;
    // 12-bit format packs the channel low
    wr(asf_pkg::CTRL_OFF, 32'h0);
    rdc(asf_pkg::DIVISOR_OFF, asf_pkg::DIV_12BIT);
    conv();
    rdc(asf_pkg::DATA_OFF, {16'h0, 12'(nx), 4'(nx)});
    nx++;
    // Fill past full, then drain in order
    wr(asf_pkg::CTRL_OFF, 32'h0000_000e);
    base = nx;
    s0 = eoc_cnt;
    for (int k = 0; k < 1026; k++) begin
      conv();
      `CHK({half, full}, {k >= 511, k >= 1023})
    end
    nx += 1026;
    `CHK(eoc_cnt - s0, 1024)
    `CHK(half_cnt, 1)
    for (int k = 0; k < 1024; k++) begin
      // Full: check before a read; half and not full: one block unchecked
      if (k == 1) `CHK({half, full}, 2'b10)
      if (k == 0 || k > 512) `CHK(nef, 1'b1)
      rdc(asf_pkg::DATA_OFF, 32'(base + k));
    end
    `CHK(nef, 1'b0)
    // Mute converter, deadline still stores a word
    delay <= 10'h000;
    conv();
    `CHK({idle, nef}, 2'b11)
    delay <= 10'h003;
    // Pre-trigger stop for the smallest and a larger count
    for (int n = 1; n <= 3; n += 2) begin
      wr(asf_pkg::CTRL_OFF, 32'h0);
      wr(asf_pkg::STOPCNT_OFF, 32'(n));
      wr(asf_pkg::CTRL_OFF, 32'h0000_0001);
      s0 = start_cnt;
      repeat (2) conv();
      `CHK(start_cnt - s0, 2)
      @(posedge clk_i);
      pretrigger_input <= 1'b0;
      repeat (3) @(posedge clk_i);
      s0 = start_cnt;
      repeat (n + 2) conv();
      `CHK(start_cnt - s0, n)
      `CHK(stopped, 1'b1)
      rdc(asf_pkg::STOPCNT_OFF, 32'h0);
      @(posedge clk_i);
      pretrigger_input <= 1'b1;
    end
    test_done();
  end
endmodule // tb_adc_sample_fifo_pretrigger
